// >>> hw/dpg_gpio.sv
// Dual port GPIO: 8-bit data-shared port and 4-bit address-shared port
//
// Operation
// - Single-chip: data-port pin outputs when direction bit 1, input when 0.
// - Data-port direction register is write-only; reads return all ones.
// - Data-port direction clears on reset or hardware standby, else holds.
// - Software standby leaves direction untouched; outputs keep driving.
// - Data-port output data register, 8-bit read/write, drives output pins.
// - Data-port read: stored bit when direction 1, pin level when 0.
// - Data-port output data clears on reset or hardware standby, else holds.
// - Data-port pull-up on when pull-up bit 1, direction 0, narrow bus.
// - Data-port pull-ups off in reset, hardware standby and wide bus.
// - Data-port pull-up register clears on reset/hardware standby, retained.
// - Modes 1-4: address-port direction fixed 1, pins are upper addresses.
// - Mode 5: address-port pins start input; direction 1 gives address out.
// - Single-chip: address-port pin general output when direction 1.
// - Address-port direction reads ones; writes ignored in modes 1-4.
// - Address-port direction resets to FF in modes 1-4, F0 otherwise.
// - Address-port read: stored bit or pin level; upper nibble reads ones.
// - Address-port data resets to F0 and holds in software standby.
// - Modes 5-7: address-port pull-up when direction 0 and pull-up bit 1.
// - Address-port pull-up register resets to F0, retained in soft standby.
// - Expanded wide bus: data port is data bus, direction bits ignored.
// - Expanded narrow bus: data port is general I/O under direction bits.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "dpg_defines.svh"

module dpg_gpio
  import dpg_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_PINS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hw_standby_i,
  input wire logic [2:0] mode_i,
  input wire logic wide_bus_i,
  input wire logic [19:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] data_pin_i,
  output logic [7:0] data_pin_o,
  output logic [7:0] data_pin_oe_o,
  output logic [7:0] data_pullup_o,
  input wire logic [3:0] addr_pin_i,
  input wire logic [3:0] upper_address_outputs_i,
  output logic [3:0] addr_pin_o,
  output logic [3:0] addr_pin_oe_o,
  output logic [3:0] addr_pullup_o
);

  initial begin
    if (DATA_W != 8 || ADDR_PINS != `DPG_NIB_W) begin
      $error("dpg_gpio supports only 8 data pins and 4 address pins");
    end
  end

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  function automatic logic is_addr_only(input logic [2:0] m);
    is_addr_only = (m >= 3'(DPG_MODE_1)) && (m <= 3'(DPG_MODE_4));
  endfunction : is_addr_only

  function automatic logic is_single(input logic [2:0] m);
    is_single = (m == 3'(DPG_MODE_6)) || (m == 3'(DPG_MODE_7));
  endfunction : is_single

  logic addr_only;
  logic single_chip;
  logic data_gpio;
  logic init_now;
  assign addr_only = is_addr_only(mode_i);
  assign single_chip = is_single(mode_i);
  // Data port is I/O in single-chip, or expanded with narrow bus
  assign data_gpio = single_chip || !wide_bus_i;
  assign init_now = hw_standby_i;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic wr_ddir, wr_ddr, wr_dpcr, wr_adir, wr_adr, wr_apcr;
  assign wr_ddir = reg_wr_i && reg_addr_i == `DPG_OFS_DATA_DIR;
  assign wr_ddr = reg_wr_i && reg_addr_i == `DPG_OFS_DATA_DR;
  assign wr_dpcr = reg_wr_i && reg_addr_i == `DPG_OFS_DATA_PCR;
  assign wr_adir = reg_wr_i && reg_addr_i == `DPG_OFS_ADDR_DIR;
  assign wr_adr = reg_wr_i && reg_addr_i == `DPG_OFS_ADDR_DR;
  assign wr_apcr = reg_wr_i && reg_addr_i == `DPG_OFS_ADDR_PCR;

  // ----------------------------------------------------------------
  // Data port registers
  // ----------------------------------------------------------------
  logic [7:0] data_port_direction_ff;
  logic [7:0] data_port_output_data_ff;
  logic [7:0] data_port_pullup_enable_ff;

  // Hardware standby clears; software standby has no effect (retention)
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_port_direction_ff <= `DPG_RST_DATA;
    end else if (init_now) begin
      data_port_direction_ff <= `DPG_RST_DATA;
    end else if (wr_ddir) begin
      data_port_direction_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_port_output_data_ff <= `DPG_RST_DATA;
    end else if (init_now) begin
      data_port_output_data_ff <= `DPG_RST_DATA;
    end else if (wr_ddr) begin
      data_port_output_data_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_port_pullup_enable_ff <= `DPG_RST_DATA;
    end else if (init_now) begin
      data_port_pullup_enable_ff <= `DPG_RST_DATA;
    end else if (wr_dpcr) begin
      data_port_pullup_enable_ff <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Address port registers (low nibble stored, high nibble fixed 1)
  // ----------------------------------------------------------------
  logic [3:0] addr_port_direction_ff;
  logic [3:0] addr_port_output_data_ff;
  logic [3:0] addr_port_pullup_enable_ff;
  logic [3:0] adir_init;
  assign adir_init = addr_only ? 4'(`DPG_RST_ADDR_DIR_AO) :
    4'(`DPG_RST_ADDR_HI);

  // Reset value is a constant; mode-dependent value is loaded after release
  logic init_done_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_done_ff <= 1'b0;
    end else begin
      init_done_ff <= !init_now;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_port_direction_ff <= 4'(`DPG_RST_ADDR_HI);
    end else if (init_now || !init_done_ff || addr_only) begin
      addr_port_direction_ff <= adir_init;
    end else if (wr_adir) begin
      addr_port_direction_ff <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_port_output_data_ff <= 4'(`DPG_RST_ADDR_HI);
    end else if (init_now) begin
      addr_port_output_data_ff <= 4'(`DPG_RST_ADDR_HI);
    end else if (wr_adr) begin
      addr_port_output_data_ff <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_port_pullup_enable_ff <= 4'(`DPG_RST_ADDR_HI);
    end else if (init_now) begin
      addr_port_pullup_enable_ff <= 4'(`DPG_RST_ADDR_HI);
    end else if (wr_apcr) begin
      addr_port_pullup_enable_ff <= reg_wdata_i[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] dpin_s1_ff, dpin_s2_ff;
  logic [3:0] apin_s1_ff, apin_s2_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dpin_s1_ff <= `DPG_RST_DATA;
      dpin_s2_ff <= `DPG_RST_DATA;
      apin_s1_ff <= '0;
      apin_s2_ff <= '0;
    end else begin
      dpin_s1_ff <= data_pin_i;
      dpin_s2_ff <= dpin_s1_ff;
      apin_s1_ff <= addr_pin_i;
      apin_s2_ff <= apin_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `DPG_OFS_DATA_DIR: nxt_rdata = `DPG_ALL_ONES;
        `DPG_OFS_DATA_DR: nxt_rdata =
          (data_port_direction_ff & data_port_output_data_ff) |
          (~data_port_direction_ff & dpin_s2_ff);
        `DPG_OFS_DATA_PCR: nxt_rdata = data_port_pullup_enable_ff;
        `DPG_OFS_ADDR_DIR: nxt_rdata = `DPG_ALL_ONES;
        `DPG_OFS_ADDR_DR: nxt_rdata = {4'hF,
          (addr_port_direction_ff & addr_port_output_data_ff) |
          (~addr_port_direction_ff & apin_s2_ff)};
        `DPG_OFS_ADDR_PCR: nxt_rdata = {4'hF, addr_port_pullup_enable_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and pull-ups
  // ----------------------------------------------------------------
  logic [7:0] nxt_doe, nxt_dpu;
  logic [3:0] nxt_aout, nxt_aoe, nxt_apu;
  logic mode5;
  assign mode5 = mode_i == 3'(DPG_MODE_5);

  always_comb begin
    // Wide bus hands the pins to the bus controller
    nxt_doe = data_gpio ? data_port_direction_ff : '0;
    nxt_dpu = (data_gpio && !init_now) ?
      (data_port_pullup_enable_ff & ~data_port_direction_ff) : '0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < ADDR_PINS; gi++) begin : g_apin
      always_comb begin
        nxt_aoe[gi] = addr_only | addr_port_direction_ff[gi];
        nxt_aout[gi] = (addr_only | mode5) ? upper_address_outputs_i[gi] :
          addr_port_output_data_ff[gi];
        nxt_apu[gi] = !addr_only && !init_now &&
          addr_port_pullup_enable_ff[gi] &&
          !addr_port_direction_ff[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_pin_o <= '0;
      data_pin_oe_o <= '0;
      data_pullup_o <= '0;
      addr_pin_o <= '0;
      addr_pin_oe_o <= '0;
      addr_pullup_o <= '0;
    end else begin
      data_pin_o <= data_port_output_data_ff;
      data_pin_oe_o <= nxt_doe;
      data_pullup_o <= nxt_dpu;
      addr_pin_o <= nxt_aout;
      addr_pin_oe_o <= nxt_aoe;
      addr_pullup_o <= nxt_apu;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Direction register never reads back
  a_ddir_read_ones: assert property (
    reg_rd_i && reg_addr_i == `DPG_OFS_DATA_DIR |=>
      reg_rdata_o == `DPG_ALL_ONES)
    else $error("direction read not all ones");

  // Wide bus takes the data pins away from the pull-ups
  a_dpu_wide_off: assert property (
    !single_chip && wide_bus_i |=> data_pullup_o == `DPG_RST_DATA)
    else $error("pull-up on in wide bus");

  // Standby forces the data pull-ups off
  a_dpu_hws_off: assert property (
    hw_standby_i |=> data_pullup_o == `DPG_RST_DATA)
    else $error("pull-up on in hardware standby");

  // Pull-up on pin 1 comes on with its bit when pin 1 is an input
  a_dpu_input_on: assert property (
    data_gpio && !init_now && data_port_pullup_enable_ff[1] &&
      !data_port_direction_ff[1] |=> data_pullup_o[1])
    else $error("pull-up not on for input pin");

  // Single-chip output enables follow direction
  a_doe_follows_dir: assert property (
    single_chip |=> data_pin_oe_o == $past(data_port_direction_ff))
    else $error("output enable mismatch");

  // Wide bus ignores the direction bits
  a_doe_wide_off: assert property (
    !single_chip && wide_bus_i |=> data_pin_oe_o == `DPG_RST_DATA)
    else $error("data pin driven in wide bus");

  // Data pins carry the stored output byte
  a_dout_follows: assert property (
    1'b1 |=> data_pin_o == $past(data_port_output_data_ff))
    else $error("data pin value mismatch");

  // Hardware standby clears direction and data
  a_hws_clears_dir: assert property (
    hw_standby_i |=> data_port_direction_ff == `DPG_RST_DATA &&
      data_port_output_data_ff == `DPG_RST_DATA)
    else $error("hardware standby did not clear");

  // Hardware standby clears the pull-up register
  a_dpcr_hws_clear: assert property (
    hw_standby_i |=> data_port_pullup_enable_ff == `DPG_RST_DATA)
    else $error("pull-up register not cleared");

  // Address-only modes drive every address pin
  a_aoe_addr_only: assert property (
    addr_only |=> addr_pin_oe_o == 4'(`DPG_ALL_ONES))
    else $error("address pins not driven");

  // Address-only modes keep the direction bits at one
  a_adir_fixed: assert property (
    addr_only |=> addr_port_direction_ff == 4'(`DPG_ALL_ONES))
    else $error("address direction not fixed");

  // Standby reloads the direction nibble outside address-only modes
  a_adir_hws_init: assert property (
    hw_standby_i && !addr_only |=>
      addr_port_direction_ff == 4'(`DPG_RST_ADDR_HI))
    else $error("address direction not reloaded");

  // Mode five enables address pins by direction bit
  a_aoe_mode5_dir: assert property (
    mode5 |=> addr_pin_oe_o == $past(addr_port_direction_ff))
    else $error("mode five enable mismatch");

  // Single-chip address pins carry the data register
  a_aout_single: assert property (
    single_chip |=> addr_pin_o == $past(addr_port_output_data_ff))
    else $error("address pin value mismatch");

  // Reserved upper nibble reads as ones
  a_adr_read_hi: assert property (
    reg_rd_i && reg_addr_i == `DPG_OFS_ADDR_DR |=>
      reg_rdata_o[7:4] == 4'(`DPG_ALL_ONES))
    else $error("upper nibble not ones");

  // No address pull-ups where the pins carry addresses
  a_apu_addr_off: assert property (
    addr_only |=> addr_pullup_o == 4'(`DPG_RST_DATA))
    else $error("address pull-up on");

  // Stored byte reads back on an output port
  a_ddr_write_read: assert property (
    wr_ddr && !init_now ##1 reg_rd_i &&
      reg_addr_i == `DPG_OFS_DATA_DR &&
      data_port_direction_ff == `DPG_ALL_ONES |=>
      reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("stored data not read back");

  c_data_out: cover property (
    single_chip && wr_ddir ##1 wr_ddr);
  c_pullup_on: cover property (
    data_pullup_o != `DPG_RST_DATA);
  c_mode5_addr: cover property (
    mode5 && addr_pin_oe_o != 4'(`DPG_RST_DATA));
  c_wide_bus: cover property (
    !single_chip && wide_bus_i);

endmodule : dpg_gpio

// >>> hw/dpg_defines.svh
// Register offsets, reset values and field constants of the dual port GPIO
`ifndef DPG_DEFINES_SVH
`define DPG_DEFINES_SVH
`define DPG_OFS_DATA_DIR 20'h0_EE003
`define DPG_OFS_DATA_DR 20'hF_FFD3
`define DPG_OFS_DATA_PCR 20'h0_EE03E
`define DPG_OFS_ADDR_DIR 20'h0_EE004
`define DPG_OFS_ADDR_DR 20'hF_FFD4
`define DPG_OFS_ADDR_PCR 20'h0_EE03F
`define DPG_RST_DATA 8'h00
`define DPG_RST_ADDR_DIR_AO 8'hFF
`define DPG_RST_ADDR_HI 8'hF0
`define DPG_ALL_ONES 8'hFF
`define DPG_ADDR_W 20
`define DPG_NIB_W 4
`endif

// >>> hw/dpg_pkg.sv
// Types of the dual port GPIO block
package dpg_pkg;
  typedef enum logic [2:0] {
    DPG_MODE_0 = 3'h0,
    DPG_MODE_1 = 3'h1,
    DPG_MODE_2 = 3'h2,
    DPG_MODE_3 = 3'h3,
    DPG_MODE_4 = 3'h4,
    DPG_MODE_5 = 3'h5,
    DPG_MODE_6 = 3'h6,
    DPG_MODE_7 = 3'h7
  } dpg_mode_e;
endpackage : dpg_pkg

// >>> verification/dpg_pin_board.sv
// Board model of one GPIO port: pins, outside drivers and pull-ups
`timescale 1ns/1ps

module dpg_pin_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] drv_oe_i,
  input wire logic [W-1:0] pullup_i,
  input wire logic [W-1:0] ext_en_i,
  input wire logic [W-1:0] ext_i,
  output logic [W-1:0] level_o
);
  // --------------------------------------------------------------
  // Pin level
  // --------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (drv_oe_i[b]) begin
        level_o[b] = drv_i[b];
      end else if (ext_en_i[b]) begin
        level_o[b] = ext_i[b];
      end else if (pullup_i[b]) begin
        level_o[b] = 1'b1;
      end else begin
        // Floating pin shows the opposite of the present drv_i value
        level_o[b] = ~drv_i[b];
      end
    end
  end
endmodule : dpg_pin_board

// >>> verification/dual_port_gpio_pullup_ctrl_tb_top.sv
// Self-checking bench of the dual port GPIO
`timescale 1ns/1ps
`include "dpg_defines.svh"
`define CHK(g, e) check(8'(g), 8'(e))

module dual_port_gpio_pullup_ctrl_tb_top;
  import dpg_pkg::*;
  typedef struct packed {
    logic wr;
    logic [19:0] a;
    logic [7:0] d;
    logic [7:0] x;
  } dpg_row_s;
  localparam logic [19:0] DR_D = 20'hF_FFD3;
  localparam logic [19:0] DR_A = 20'hF_FFD4;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hw_standby_i = 1'b0;
  logic wide_bus_i = 1'b0;
  logic [2:0] mode_i = 3'h7;
  logic [19:0] reg_addr_i = 20'h0_0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] upper_address_outputs_i = 4'h0;
  logic [7:0] d_ext_en = 8'hFF;
  logic [7:0] d_ext = 8'hC3;
  logic [3:0] a_ext_en = 4'hF;
  logic [3:0] a_ext = 4'h9;
  logic [7:0] reg_rdata_o, data_pin_i, data_pin_o, data_pin_oe_o;
  logic [7:0] data_pullup_o;
  logic [3:0] addr_pin_i, addr_pin_o, addr_pin_oe_o, addr_pullup_o;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  dpg_row_s rows [15] = '{
    '{1'b0, `DPG_OFS_DATA_PCR, 8'h00, 8'h00},
    '{1'b0, `DPG_OFS_ADDR_PCR, 8'h00, 8'hF0},
    '{1'b0, `DPG_OFS_ADDR_DIR, 8'h00, 8'hFF},
    '{1'b0, DR_D, 8'h00, 8'hC3},
    '{1'b1, `DPG_OFS_DATA_DIR, 8'hFF, 8'hFF},
    '{1'b0, DR_D, 8'h00, 8'h00},
    '{1'b1, DR_D, 8'hA5, 8'hA5},
    '{1'b1, `DPG_OFS_DATA_DIR, 8'h0F, 8'hFF},
    '{1'b0, DR_D, 8'h00, 8'hC5},
    '{1'b1, `DPG_OFS_DATA_PCR, 8'h5A, 8'h5A},
    '{1'b1, DR_A, 8'h0A, 8'hF9},
    '{1'b1, `DPG_OFS_ADDR_DIR, 8'h03, 8'hFF},
    '{1'b0, DR_A, 8'h00, 8'hFA},
    '{1'b1, `DPG_OFS_ADDR_PCR, 8'h0C, 8'hFC},
    '{1'b1, 20'h0_0000, 8'hFF, 8'h00}};

  always #4 clk_i = ~clk_i;
  // --------------------------------------------------------------
  // Design and board
  // --------------------------------------------------------------
  dpg_gpio dut_u (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i),
    .mode_i(mode_i), .wide_bus_i(wide_bus_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .data_pin_i(data_pin_i),
    .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o),
    .data_pullup_o(data_pullup_o), .addr_pin_i(addr_pin_i),
    .upper_address_outputs_i(upper_address_outputs_i),
    .addr_pin_o(addr_pin_o), .addr_pin_oe_o(addr_pin_oe_o),
    .addr_pullup_o(addr_pullup_o));
  dpg_pin_board #(.W(8)) data_brd_u (.drv_i(data_pin_o),
    .drv_oe_i(data_pin_oe_o), .pullup_i(data_pullup_o), .ext_en_i(d_ext_en),
    .ext_i(d_ext), .level_o(data_pin_i));
  dpg_pin_board #(.W(4)) addr_brd_u (.drv_i(addr_pin_o),
    .drv_oe_i(addr_pin_oe_o), .pullup_i(addr_pullup_o), .ext_en_i(a_ext_en),
    .ext_i(a_ext), .level_o(addr_pin_i));
  // --------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [19:0] a, output logic [7:0] r);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    r = reg_rdata_o;
  endtask : rd

  task automatic do_reset(input logic [2:0] m);
    rst_i <= 1'b1;
    mode_i <= m;
    settle(4);
    rst_i <= 1'b0;
    settle(4);
  endtask : do_reset

  task automatic close_out();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    logic [7:0] r;
    do_reset(3'h7);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      settle(4);
      rd(rows[i].a, r);
      `CHK(r, rows[i].x);
    end
    `CHK(data_pin_oe_o, 8'h0F);
    `CHK(data_pin_o & data_pin_oe_o, 8'h05);
    `CHK(data_pullup_o, 8'h50);
    `CHK(addr_pin_oe_o, 4'h3);
    `CHK(addr_pin_o & addr_pin_oe_o, 4'h2);
    `CHK(addr_pullup_o, 4'hC);
    // Write then read in the very next cycle
    wr(`DPG_OFS_DATA_DIR, 8'hFF);
    wr(DR_D, 8'h3C);
    rd(DR_D, r);
    `CHK(r, 8'h3C);
    hw_standby_i <= 1'b1;
    settle(3);
    `CHK(data_pullup_o, 8'h00);
    hw_standby_i <= 1'b0;
    settle(3);
    `CHK(data_pin_oe_o, 8'h00);
    `CHK(addr_pin_oe_o, 4'h0);
    upper_address_outputs_i <= 4'h5;
    do_reset(3'h1);
    `CHK(addr_pin_oe_o, 4'hF);
    `CHK(addr_pin_o, 4'h5);
    wr(`DPG_OFS_ADDR_DIR, 8'h00);
    rd(`DPG_OFS_ADDR_DIR, r);
    `CHK(r, 8'hFF);
    wr(`DPG_OFS_ADDR_PCR, 8'h0F);
    wr(`DPG_OFS_DATA_PCR, 8'hFF);
    wr(`DPG_OFS_DATA_DIR, 8'h81);
    wide_bus_i <= 1'b1;
    settle(3);
    `CHK(addr_pin_oe_o, 4'hF);
    `CHK(addr_pullup_o, 4'h0);
    `CHK(data_pullup_o, 8'h00);
    `CHK(data_pin_oe_o, 8'h00);
    wide_bus_i <= 1'b0;
    settle(3);
    `CHK(data_pin_oe_o, 8'h81);
    `CHK(data_pullup_o, 8'h7E);
    do_reset(3'h5);
    `CHK(addr_pin_oe_o, 4'h0);
    wr(`DPG_OFS_ADDR_DIR, 8'h01);
    settle(3);
    `CHK(addr_pin_oe_o, 4'h1);
    `CHK(addr_pin_o[0], 1'b1);
    close_out();
  end
endmodule : dual_port_gpio_pullup_ctrl_tb_top
